//--- src/ovrd_defs.svh
`ifndef OVRD_DEFS_SVH
`define OVRD_DEFS_SVH

// register byte offsets
`define OVRD_ADDR_CTRL 12'h000
`define OVRD_ADDR_FLAGS 12'h004
`define OVRD_ADDR_IRQ_STAT 12'h008
`define OVRD_ADDR_IRQ_MASK 12'h00C

// control register field positions
`define OVRD_CTRL_HIGH_LSB 0
`define OVRD_CTRL_LOW_LSB 8
`define OVRD_CTRL_HOLD_LSB 16
`define OVRD_CTRL_MODE_LSB 24

// reset values
`define OVRD_RST_HIGH_THR 8'hE4
`define OVRD_RST_LOW_THR 8'h40
`define OVRD_RST_HOLD 3'h0
`define OVRD_RST_MODE 5'h00

// link mode codes that select the embedding format
`define OVRD_MODE_REAL 5'h09
`define OVRD_MODE_CPLX_FIRST 5'h0A
`define OVRD_MODE_CPLX_LAST 5'h10
`define OVRD_MODE_CPLX_EXCL 5'h0C

// pin pulse length is 2^(hold + 3) clock cycles, 8 to 1024
`define OVRD_PIN_SHIFT_BASE 4'h3
// saturated magnitude of the most negative code
`define OVRD_MAG_SAT 8'hFF
`define OVRD_NEG_FULL 12'h800

// lanes: 0..3 pin flags, 4..7 embedded indicators
`define OVRD_LANES 8
`define OVRD_HOLD_CW 11

`endif

//--- src/ovrd_hold.sv
`timescale 1ns/1ps
`include "ovrd_defs.svh"
module ovrd_hold #(
	parameter int LANES = `OVRD_LANES,
	parameter int CW = `OVRD_HOLD_CW
) (
	input wire logic clk,
	input wire logic rst,
	ovrd_lane_if.hold lanes
);
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			logic [CW-1:0] cnt_ff;
			logic [CW-1:0] nxt_cnt;
			always_comb begin
				nxt_cnt = cnt_ff;
				if (lanes.hit[g]) begin
					nxt_cnt = CW'(1) << lanes.shift[g];
				end else if (lanes.en[g] && cnt_ff != '0) begin
					nxt_cnt = cnt_ff - CW'(1);
				end
			end
			always_ff @(posedge clk) begin
				if (rst) begin
					cnt_ff <= '0;
				end else begin
					cnt_ff <= nxt_cnt;
				end
			end
			assign lanes.active[g] = (cnt_ff != '0);
		end
	endgenerate
endmodule : ovrd_hold

//--- src/ovrd_lane_if.sv
`timescale 1ns/1ps
interface ovrd_lane_if #(parameter int LANES = 8);
	logic [LANES-1:0] hit;
	logic [LANES-1:0] en;
	logic [3:0] shift [LANES];
	logic [LANES-1:0] active;
	modport ctl (output hit, output en, output shift, input active);
	modport hold (input hit, input en, input shift, output active);
endinterface : ovrd_lane_if

//--- src/ovrd_pkg.sv
package ovrd_pkg;
	typedef enum logic [1:0] {
		OVRD_FMT_NONE = 2'b00,
		OVRD_FMT_REAL = 2'b01,
		OVRD_FMT_CPLX = 2'b10
	} ovrd_fmt_e;

	typedef enum logic [0:0] {
		OVRD_APB_IDLE = 1'b0,
		OVRD_APB_ACK = 1'b1
	} ovrd_apb_e;
endpackage : ovrd_pkg

//--- src/ovrd_top.sv
`timescale 1ns/1ps
`include "ovrd_defs.svh"
// Overview of operation
// - take magnitude of each 12-bit sample, compare its upper 8 bits to thresholds
// - the same two thresholds serve both channel A and channel B
// - two's complement input; -2048 saturates so its upper bits compare as 255
// - a flag is 1 when magnitude is at or above its threshold, else 0
// - four pin flags: A high, A low, B high, B low
// - pin flags last 8 to 1024 cycles after last event, per 3-bit hold setting
// - decimating modes also embed overrange status in output samples
// - complex: I word carries high status as LSB, Q word low status
// - real: even samples carry high status, odd samples low status
// - embedded period is 2^(hold+1) samples for real, 2^hold for complex
// - mode 9 is real, modes 10 to 16 except 12 are complex
module ovrd_top (
	input wire logic clk,
	input wire logic rst,
	// converter samples, one per channel, on the sampling clock
	input wire logic sample_valid,
	input wire logic [11:0] sample_a,
	input wire logic [11:0] sample_b,
	// decimated words from the down-converter
	input wire logic dec_valid,
	input wire logic dec_is_q,
	input wire logic [15:0] dec_a_data,
	input wire logic [15:0] dec_b_data,
	output logic out_valid,
	output logic [15:0] out_a_data,
	output logic [15:0] out_b_data,
	output logic chan_a_high_flag,
	output logic chan_a_low_flag,
	output logic chan_b_high_flag,
	output logic chan_b_low_flag,
	output logic irq,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	function automatic logic [7:0] mag8(input logic [11:0] s);
		logic [11:0] n;
		n = s[11] ? (~s + 12'h001) : s;
		if (s == `OVRD_NEG_FULL) begin
			return `OVRD_MAG_SAT;
		end
		return n[10:3];
	endfunction : mag8

	function automatic ovrd_pkg::ovrd_fmt_e fmt_of(input logic [4:0] m);
		if (m == `OVRD_MODE_REAL) begin
			return ovrd_pkg::OVRD_FMT_REAL;
		end
		if (m >= `OVRD_MODE_CPLX_FIRST && m <= `OVRD_MODE_CPLX_LAST && m != `OVRD_MODE_CPLX_EXCL) begin
			return ovrd_pkg::OVRD_FMT_CPLX;
		end
		return ovrd_pkg::OVRD_FMT_NONE;
	endfunction : fmt_of

	logic [7:0] high_threshold_ff;
	logic [7:0] low_threshold_ff;
	logic [2:0] hold_length_select_ff;
	logic [4:0] link_mode_select_ff;
	logic [3:0] irq_stat_ff;
	logic [3:0] irq_mask_ff;
	logic [3:0] flags_prev_ff;
	logic [31:0] prdata_ff;
	logic slverr_ff;
	ovrd_pkg::ovrd_apb_e apb_state_ff;
	logic parity_ff;
	logic out_valid_ff;
	logic [15:0] out_a_ff;
	logic [15:0] out_b_ff;

	logic [7:0] mag_a;
	logic [7:0] mag_b;
	logic [3:0] pin_flags;
	logic [3:0] emb;
	ovrd_pkg::ovrd_fmt_e fmt;
	logic [3:0] emb_shift;
	logic access;
	logic fire;
	logic wr_fire;
	logic addr_ok;
	logic [31:0] rd_mux;

	ovrd_lane_if #(.LANES(`OVRD_LANES)) lanes ();

	assign mag_a = mag8(sample_a);
	assign mag_b = mag8(sample_b);
	assign fmt = fmt_of(link_mode_select_ff);

	assign emb_shift = (fmt == ovrd_pkg::OVRD_FMT_REAL) ? {1'b0, hold_length_select_ff} + 4'h1
		: {1'b0, hold_length_select_ff};

	assign lanes.hit[0] = sample_valid && (mag_a >= high_threshold_ff);
	assign lanes.hit[1] = sample_valid && (mag_a >= low_threshold_ff);
	assign lanes.hit[2] = sample_valid && (mag_b >= high_threshold_ff);
	assign lanes.hit[3] = sample_valid && (mag_b >= low_threshold_ff);
	assign lanes.hit[7:4] = lanes.hit[3:0];

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_cfg
			assign lanes.en[g] = 1'b1;
			assign lanes.shift[g] = {1'b0, hold_length_select_ff} + `OVRD_PIN_SHIFT_BASE;
			// embedded windows count converter samples
			assign lanes.en[g+4] = sample_valid;
			assign lanes.shift[g+4] = emb_shift;
		end
	endgenerate

	ovrd_hold #(.LANES(`OVRD_LANES), .CW(`OVRD_HOLD_CW)) u_hold (
		.clk(clk),
		.rst(rst),
		.lanes(lanes)
	);

	assign pin_flags = lanes.active[3:0];
	assign emb = lanes.active[7:4];
	// pin order: first of a pair follows high threshold
	assign chan_a_high_flag = pin_flags[0];
	assign chan_a_low_flag = pin_flags[1];
	assign chan_b_high_flag = pin_flags[2];
	assign chan_b_low_flag = pin_flags[3];

	// real-mode sample parity; first word after entering the mode is even
	always_ff @(posedge clk) begin
		if (rst) begin
			parity_ff <= 1'b0;
		end else if (fmt != ovrd_pkg::OVRD_FMT_REAL) begin
			parity_ff <= 1'b0;
		end else if (dec_valid) begin
			parity_ff <= ~parity_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			out_valid_ff <= 1'b0;
			out_a_ff <= 16'h0000;
			out_b_ff <= 16'h0000;
		end else begin
			out_valid_ff <= dec_valid;
			if (dec_valid) begin
				case (fmt)
					// I carries high, Q carries low
					ovrd_pkg::OVRD_FMT_CPLX: begin
						out_a_ff <= {dec_a_data[15:1], dec_is_q ? emb[1] : emb[0]};
						out_b_ff <= {dec_b_data[15:1], dec_is_q ? emb[3] : emb[2]};
					end
					ovrd_pkg::OVRD_FMT_REAL: begin
						out_a_ff <= {dec_a_data[15:1], parity_ff ? emb[1] : emb[0]};
						out_b_ff <= {dec_b_data[15:1], parity_ff ? emb[3] : emb[2]};
					end
					default: begin
						out_a_ff <= dec_a_data;
						out_b_ff <= dec_b_data;
					end
				endcase
			end
		end
	end
	assign out_valid = out_valid_ff;
	assign out_a_data = out_a_ff;
	assign out_b_data = out_b_ff;

	// APB: one wait state so read data comes from a flip-flop
	assign access = psel && penable;
	assign fire = access && (apb_state_ff == ovrd_pkg::OVRD_APB_ACK);
	assign wr_fire = fire && pwrite;
	assign addr_ok = (paddr == `OVRD_ADDR_CTRL) || (paddr == `OVRD_ADDR_FLAGS)
		|| (paddr == `OVRD_ADDR_IRQ_STAT) || (paddr == `OVRD_ADDR_IRQ_MASK);

	always_ff @(posedge clk) begin
		if (rst) begin
			apb_state_ff <= ovrd_pkg::OVRD_APB_IDLE;
		end else begin
			case (apb_state_ff)
				ovrd_pkg::OVRD_APB_IDLE: begin
					if (access) begin
						apb_state_ff <= ovrd_pkg::OVRD_APB_ACK;
					end
				end
				ovrd_pkg::OVRD_APB_ACK: begin
					apb_state_ff <= ovrd_pkg::OVRD_APB_IDLE;
				end
				default: begin
					apb_state_ff <= ovrd_pkg::OVRD_APB_IDLE;
				end
			endcase
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (paddr)
			`OVRD_ADDR_CTRL: begin
				rd_mux[`OVRD_CTRL_HIGH_LSB +: 8] = high_threshold_ff;
				rd_mux[`OVRD_CTRL_LOW_LSB +: 8] = low_threshold_ff;
				rd_mux[`OVRD_CTRL_HOLD_LSB +: 3] = hold_length_select_ff;
				rd_mux[`OVRD_CTRL_MODE_LSB +: 5] = link_mode_select_ff;
			end
			`OVRD_ADDR_FLAGS: begin
				rd_mux[7:0] = lanes.active;
			end
			`OVRD_ADDR_IRQ_STAT: begin
				rd_mux[3:0] = irq_stat_ff;
			end
			`OVRD_ADDR_IRQ_MASK: begin
				rd_mux[3:0] = irq_mask_ff;
			end
			default: begin
				rd_mux = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			prdata_ff <= 32'h0000_0000;
			slverr_ff <= 1'b0;
		end else if (access && apb_state_ff == ovrd_pkg::OVRD_APB_IDLE) begin
			prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
			slverr_ff <= ~addr_ok;
		end
	end
	assign pready = fire;
	assign pslverr = fire && slverr_ff;
	assign prdata = prdata_ff;

	// configuration takes effect from the cycle after the write
	always_ff @(posedge clk) begin
		if (rst) begin
			high_threshold_ff <= `OVRD_RST_HIGH_THR;
			low_threshold_ff <= `OVRD_RST_LOW_THR;
			hold_length_select_ff <= `OVRD_RST_HOLD;
			link_mode_select_ff <= `OVRD_RST_MODE;
		end else if (wr_fire && paddr == `OVRD_ADDR_CTRL) begin
			high_threshold_ff <= pwdata[`OVRD_CTRL_HIGH_LSB +: 8];
			low_threshold_ff <= pwdata[`OVRD_CTRL_LOW_LSB +: 8];
			hold_length_select_ff <= pwdata[`OVRD_CTRL_HOLD_LSB +: 3];
			link_mode_select_ff <= pwdata[`OVRD_CTRL_MODE_LSB +: 5];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irq_mask_ff <= 4'h0;
		end else if (wr_fire && paddr == `OVRD_ADDR_IRQ_MASK) begin
			irq_mask_ff <= pwdata[3:0];
		end
	end

	// a rising pin flag sets its sticky bit; a set beats a same-cycle clear
	always_ff @(posedge clk) begin
		if (rst) begin
			flags_prev_ff <= 4'h0;
			irq_stat_ff <= 4'h0;
		end else begin
			flags_prev_ff <= pin_flags;
			irq_stat_ff <= (irq_stat_ff & ~((wr_fire && paddr == `OVRD_ADDR_IRQ_STAT) ? pwdata[3:0] : 4'h0))
				| (pin_flags & ~flags_prev_ff);
		end
	end
	assign irq = |(irq_stat_ff & irq_mask_ff);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	property p_upper_only;
		(sample_valid && sample_a == 12'h007 && high_threshold_ff == 8'h01) |-> !lanes.hit[0];
	endproperty
	a_upper_only: assert property (p_upper_only) else $error("low magnitude bits took part in compare");

	property p_neg_sat;
		(sample_valid && sample_a == 12'h800 && high_threshold_ff == 8'hFF) |=> chan_a_high_flag;
	endproperty
	a_neg_sat: assert property (p_neg_sat) else $error("most negative code did not compare as 255");

	property p_hit_sets;
		(sample_valid && mag_a >= high_threshold_ff) |=> chan_a_high_flag;
	endproperty
	a_hit_sets: assert property (p_hit_sets) else $error("high flag missed a hit on channel A");

	property p_b_shared;
		(sample_valid && mag_b >= low_threshold_ff) |=> chan_b_low_flag;
	endproperty
	a_b_shared: assert property (p_b_shared) else $error("channel B low flag ignored shared threshold");

	property p_pin_order;
		(sample_valid && mag_a >= low_threshold_ff && mag_a < high_threshold_ff && !chan_a_high_flag
			&& hold_length_select_ff == 3'h0) |=> (chan_a_low_flag && !chan_a_high_flag);
	endproperty
	a_pin_order: assert property (p_pin_order) else $error("pin pair order wrong");

	property p_hold8;
		(lanes.hit[0] && hold_length_select_ff == 3'h0) |=> chan_a_high_flag [*8];
	endproperty
	a_hold8: assert property (p_hold8) else $error("shortest pin pulse under 8 cycles");

	property p_drop_ok;
		$fell(chan_a_high_flag) |-> !$past(lanes.hit[0]);
	endproperty
	a_drop_ok: assert property (p_drop_ok) else $error("flag dropped right after a hit");

	property p_cplx_i;
		(dec_valid && !dec_is_q && fmt == ovrd_pkg::OVRD_FMT_CPLX)
			|=> (out_a_data == {$past(dec_a_data[15:1]), $past(emb[0])});
	endproperty
	a_cplx_i: assert property (p_cplx_i) else $error("I word lacks high status bit");

	property p_real_odd;
		(dec_valid && parity_ff && fmt == ovrd_pkg::OVRD_FMT_REAL)
			|=> (out_b_data == {$past(dec_b_data[15:1]), $past(emb[3])});
	endproperty
	a_real_odd: assert property (p_real_odd) else $error("odd real sample lacks low status bit");

	property p_mode12;
		(dec_valid && link_mode_select_ff == 5'h0C) |=> (out_a_data == $past(dec_a_data));
	endproperty
	a_mode12: assert property (p_mode12) else $error("mode 12 altered output data");

	property p_no_embed;
		(dec_valid && fmt == ovrd_pkg::OVRD_FMT_NONE) |=> (out_b_data == $past(dec_b_data));
	endproperty
	a_no_embed: assert property (p_no_embed) else $error("embedding outside decimating modes");

	property p_cplx_period;
		(lanes.hit[4] && fmt == ovrd_pkg::OVRD_FMT_CPLX && hold_length_select_ff == 3'h0)
			##1 (sample_valid && !lanes.hit[4] && $stable(link_mode_select_ff)) |=> !emb[0];
	endproperty
	a_cplx_period: assert property (p_cplx_period) else $error("complex window longer than one sample");

	c_pin_trip: cover property ($rose(chan_b_high_flag));
	c_real_embed: cover property (dec_valid && fmt == ovrd_pkg::OVRD_FMT_REAL && emb[1]);
	c_cplx_embed: cover property (dec_valid && dec_is_q && fmt == ovrd_pkg::OVRD_FMT_CPLX && emb[3]);
	c_irq: cover property ($rose(irq));
endmodule : ovrd_top

//--- test/ovrd_gain_model.sv
`timescale 1ns/1ps
module ovrd_gain_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] flags,
	output logic over_hi,
	output logic over_lo,
	output logic gain_up,
	output logic gain_dn
);
	logic [15:0] quiet_ff;
	assign over_hi = flags[0] | flags[2];
	assign over_lo = flags[1] | flags[3];
	assign gain_dn = over_hi;
	assign gain_up = quiet_ff == 16'hFFFF;
	// saturates so a long quiet spell keeps asking for more gain
	always_ff @(posedge clk) begin
		if (rst || over_lo) begin
			quiet_ff <= 16'h0000;
		end else if (!gain_up) begin
			quiet_ff <= quiet_ff + 16'h0001;
		end
	end
endmodule : ovrd_gain_model

//--- test/test_adc_overrange_detector.sv
`timescale 1ns/1ps
`include "ovrd_defs.svh"
module test_adc_overrange_detector;
	logic clk = 0, rst = 1, sample_valid = 0, dec_valid = 0, dec_is_q = 0;
	logic psel = 0, penable = 0, pwrite = 0, out_valid, irq, pready, pslverr, err;
	logic [11:0] sample_a = 0, sample_b = 0, paddr = 0;
	logic [15:0] dec_a_data = 0, dec_b_data = 0, out_a_data, out_b_data;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [3:0] flags;
	logic chan_a_high_flag, chan_a_low_flag, chan_b_high_flag, chan_b_low_flag, far_hi, far_lo;
	logic [11:0] tbl [7] = '{12'h800, 12'h7FF, 12'h7F0, 12'h810, 12'h000, 12'h7F7, 12'h808};
	int modes [8] = '{9, 10, 11, 12, 13, 16, 17, 0};
	int fail_count = 0, checked = 0, hi = 228, lo = 64, hold = 0, mode = 0, par = 0;
	int cnt [8];
	logic [31:0] q [$];

	always #12.5 clk = ~clk;
	assign flags = {chan_b_low_flag, chan_b_high_flag, chan_a_low_flag, chan_a_high_flag};

	ovrd_top dut_u (.clk(clk), .rst(rst), .sample_valid(sample_valid), .sample_a(sample_a),
		.sample_b(sample_b), .dec_valid(dec_valid), .dec_is_q(dec_is_q), .dec_a_data(dec_a_data),
		.dec_b_data(dec_b_data), .out_valid(out_valid), .out_a_data(out_a_data), .out_b_data(out_b_data),
		.chan_a_high_flag(chan_a_high_flag), .chan_a_low_flag(chan_a_low_flag),
		.chan_b_high_flag(chan_b_high_flag), .chan_b_low_flag(chan_b_low_flag), .irq(irq),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	ovrd_gain_model far_u (.clk(clk), .rst(rst), .flags(flags), .over_hi(far_hi), .over_lo(far_lo), .gain_up(),
		.gain_dn());

	function automatic bit hit(logic [11:0] s, int t);
		int m;
		m = $signed(s);
		if (m < 0) m = -m;
		if (m > 2047) m = 2047;
		return (m >> 3) >= t;
	endfunction : hit

	task automatic chk(logic [31:0] got, logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic close_out;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : close_out

	always @(posedge clk) begin
		int sel, len;
		logic [15:0] ea, eb;
		if (rst) begin
			cnt = '{default: 0};
			par = 0;
			q.delete();
		end else begin
			if (dec_valid) begin
				sel = (mode == 9) ? par : dec_is_q;
				ea = dec_a_data;
				eb = dec_b_data;
				if (mode == 9 || (mode >= 10 && mode <= 16 && mode != 12)) begin
					ea[0] = cnt[4 + sel] != 0;
					eb[0] = cnt[6 + sel] != 0;
				end
				q.push_back({ea, eb});
				par ^= 1;
			end
			for (int i = 0; i < 8; i++) begin
				len = (i < 4) ? 1 << (hold + 3) : (mode == 9) ? 1 << (hold + 1) : 1 << hold;
				if (sample_valid && hit((i % 4 < 2) ? sample_a : sample_b, (i % 2) ? lo : hi))
					cnt[i] = len;
				else if (cnt[i] > 0 && (i < 4 || sample_valid))
					cnt[i]--;
			end
		end
	end

	always @(negedge clk) begin
		if (!rst) begin
			chk(flags, {cnt[3] != 0, cnt[2] != 0, cnt[1] != 0, cnt[0] != 0});
			chk({far_lo, far_hi}, {cnt[1] != 0 || cnt[3] != 0, cnt[0] != 0 || cnt[2] != 0});
			if (out_valid === 1'b1) begin
				if (q.size() == 0) chk(32'h1, 32'h0);
				else chk({out_a_data, out_b_data}, q.pop_front());
			end
		end
	end

	task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		@(posedge clk);
		// the answer is taken at the rising edge that completes the transfer
		while (pready !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		if (n == 20) begin
			fail_count++;
			close_out();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic wr(logic [11:0] a, logic [31:0] d);
		apb(1'b1, a, d);
		if (a == `OVRD_ADDR_CTRL) begin
			hi = d[7:0];
			lo = d[15:8];
			hold = d[18:16];
			if (mode != d[28:24]) par = 0;
			mode = d[28:24];
		end
	endtask : wr

	task automatic step(logic v, logic [11:0] a, logic [11:0] b, logic dv);
		sample_valid <= v;
		sample_a <= a;
		sample_b <= b;
		dec_valid <= dv;
		dec_is_q <= 1'($urandom);
		dec_a_data <= 16'($urandom);
		dec_b_data <= 16'($urandom);
		@(posedge clk);
	endtask : step

	// zero samples never hit, so any counter no longer than n cycles drains before a config change
	task automatic idle(int n);
		repeat (n) step(1'b1, 12'h000, 12'h000, 1'b0);
	endtask : idle

	initial begin
		#(25 * 40000);
		fail_count++;
		close_out();
	end

	initial begin
		void'($urandom(97));
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		apb(1'b0, `OVRD_ADDR_CTRL, 32'h0);
		chk(rd, 32'h000040E4);
		apb(1'b1, 12'h010, 32'hFFFFFFFF);
		chk(err, 1'b1);
		step(1'b1, 12'h7FF, 12'h000, 1'b0);
		apb(1'b0, `OVRD_ADDR_FLAGS, 32'h0);
		chk(rd, 32'h00000033);
		idle(3);
		chk(irq, 1'b0);
		apb(1'b0, `OVRD_ADDR_IRQ_STAT, 32'h0);
		chk(rd, 32'h00000003);
		wr(`OVRD_ADDR_IRQ_MASK, 32'h00000001);
		chk(irq, 1'b1);
		apb(1'b0, `OVRD_ADDR_IRQ_MASK, 32'h0);
		chk(rd, 32'h00000001);
		wr(`OVRD_ADDR_IRQ_STAT, 32'h00000001);
		chk(irq, 1'b0);
		wr(`OVRD_ADDR_CTRL, 32'h0000FEFF);
		foreach (tbl[i]) step(1'b1, tbl[i], ~tbl[i], 1'b0);
		idle(20);
		// low magnitude bits must not reach a threshold of one
		wr(`OVRD_ADDR_CTRL, 32'h00000101);
		step(1'b1, 12'h007, 12'h008, 1'b0);
		idle(20);
		for (int h = 0; h < 8; h++) begin
			wr(`OVRD_ADDR_CTRL, {13'h0, h[2:0], 8'($urandom_range(255, 1)), 8'($urandom_range(255, 1))});
			repeat (16 << h) step($urandom_range(0, 3) == 0, 12'($urandom), 12'($urandom), 1'b0);
			idle(300);
		end
		foreach (modes[i]) begin
			wr(`OVRD_ADDR_CTRL, {3'h0, 5'(modes[i]), 5'h0, 3'($urandom_range(0, 3)),
				8'($urandom_range(255, 1)), 8'($urandom_range(255, 1))});
			repeat (300) step(1'($urandom), 12'($urandom), 12'($urandom), 1'($urandom));
			idle(300);
		end
		chk(q.size(), 32'h0);
		close_out();
	end
endmodule : test_adc_overrange_detector
